// ==== shared/srp_params.svh ====
/*
 * constants of the flow-through burst sram port: sizes, strap and
 * reset values, sleep entry and recovery counts.
 * assumes inclusion by the package, the port logic and the pin checker.
 */
`ifndef SRP_PARAMS_SVH
`define SRP_PARAMS_SVH

// organisation: 256k x 36 by default, lanes of eight data bits plus parity
`define SRP_ADDR_W 18
`define SRP_LANES 4
`define SRP_LANE_W 9
`define SRP_BURST_W 2

// sleep entry and recovery, in clock cycles
`define SRP_SLEEP_ENTER_CYC 2
`define SRP_SLEEP_EXIT_CYC 2

// reset values and read buffer depth
`define SRP_RST_SYNC 2'b00
`define SRP_RST_CNT 2'b00
`define SRP_BUF_DEPTH 2

`endif

// ==== shared/srp_pkg.sv ====
/*
 * types shared by the sram port logic and its data buffer.
 * assumes srp_params.svh is on the include path.
 */
`include "srp_params.svh"

package srp_pkg;

	// power state, gray along run -> enter -> sleep -> exit -> run
	typedef enum logic [1:0] {
		SRP_RUN = 2'b00,
		SRP_ENTER = 2'b01,
		SRP_SLEEP = 2'b11,
		SRP_EXIT = 2'b10
	} srp_pwr_t;

	// synchronous control pins as sampled at a clock rise
	typedef struct packed {
		logic clock_qualifier_n;
		logic chip_sel_a_n;
		logic chip_sel_b;
		logic chip_sel_c_n;
		logic advance_load;
		logic write_sel_n;
	} srp_ctl_t;

endpackage : srp_pkg

// ==== logic/srp_buf2.sv ====
/*
 * two-entry buffer with valid and ready on both sides.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`include "srp_params.svh"

module srp_buf2 import srp_pkg::*; #(
	parameter int W = 37
) (
	input wire logic i_clk, // clock
	input wire logic i_rstn, // async reset, active low
	input wire logic i_in_valid, // word offered
	output logic o_in_ready, // room for a word
	input wire logic [W-1:0] i_in_data, // word in
	output logic o_out_valid, // word available
	input wire logic i_out_ready, // drain takes it
	output logic [W-1:0] o_out_data // oldest word
);

	typedef struct packed {
		logic [1:0][W-1:0] ent;
		logic rd_ptr;
		logic wr_ptr;
		logic [1:0] cnt;
	} srp_buf_st_t;

	srp_buf_st_t st_reg;
	srp_buf_st_t st_next;
	logic push;
	logic pop;

	// honest flags straight from the count
	assign o_in_ready = (st_reg.cnt != 2'(`SRP_BUF_DEPTH));
	assign o_out_valid = (st_reg.cnt != 2'h0);
	assign o_out_data = st_reg.ent[st_reg.rd_ptr];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	// pointer and count update
	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.ent[st_reg.wr_ptr] = i_in_data;
			st_next.wr_ptr = ~st_reg.wr_ptr;
		end
		if (pop) begin
			st_next.rd_ptr = ~st_reg.rd_ptr;
		end
		case ({push, pop})
			2'b10: st_next.cnt = st_reg.cnt + 2'h1;
			2'b01: st_next.cnt = st_reg.cnt - 2'h1;
			default: st_next.cnt = st_reg.cnt;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule : srp_buf2

// ==== logic/srp_port.sv ====
// What this block does
// - inputs registered on clock rise; qualifier high holds burst, array and output state
// - qualified rise, all selects active, read select, load low starts read
// - read drive follows output drive enable and internal control; host holds it low
// - next operation accepted on the clock after a read starts
// - any select inactive on a load floats the data lines with the same latency as a read
// - burst counter gives four beats, wrapping in the two low address bits
// - order strap low gives linear, high gives interleaved
// - advance high steps the counter, ignoring selects and read select
// - access type captured at burst start, kept for every beat
// - write load latches address and controls and floats data lines
// - write data taken on the rise after the command
// - only lanes with active byte select change, with their parity
// - sleep keeps contents; entry and exit each take two cycles
// - accesses pending at sleep entry may be lost
// - interleaved burst address is start xor beat index
// - linear burst address is start plus beat index modulo four
// - comes out of reset deselected with data lines floating
// - any byte select mix; none active writes nothing and floats lines
/*
 * flow-through burst sram port: input registers, burst counter, write
 * pipeline, flip-flop array, sleep sequencing and data line drive.
 * assumes the host works on the same clock; sleep, output drive enable
 * and the order strap are asynchronous and pass two flip-flops.
 */
`timescale 1ns/1ps
`include "srp_params.svh"

module srp_port import srp_pkg::*; #(
	parameter int ADDR_W = `SRP_ADDR_W,
	parameter int LANES = `SRP_LANES
) (
	input wire logic I_CLK, // 250 MHz clock
	input wire logic I_RSTN, // async reset, active low
	input wire logic I_CLOCK_QUALIFIER_N, // clock qualifier, low = edge counts
	input wire logic I_CHIP_SEL_A_N, // chip select, active low
	input wire logic I_CHIP_SEL_B, // chip select, active high
	input wire logic I_CHIP_SEL_C_N, // chip select, active low
	input wire logic I_ADVANCE_LOAD, // high = advance burst, low = load
	input wire logic I_WRITE_SEL_N, // low = write, high = read
	input wire logic [LANES-1:0] I_BYTE_LANE_SEL_N, // byte selects, active low
	input wire logic [ADDR_W-1:0] I_ADDR, // address
	input wire logic [LANES*`SRP_LANE_W-1:0] I_DATA, // data and parity in
	input wire logic I_OUT_DRIVE_N, // async output drive enable, active low
	input wire logic I_SLEEP_REQUEST, // async sleep request, active high
	input wire logic I_BURST_ORDER, // strap: low linear, high interleaved
	output logic [LANES*`SRP_LANE_W-1:0] O_DATA, // data and parity out
	output logic O_DATA_OE, // high while driving data lines
	output logic O_SLEEPING // high from the entry state through sleep and exit
);

	localparam int DW = LANES * `SRP_LANE_W;
	localparam int BW = `SRP_BURST_W;
	localparam int DEPTH = 2 ** ADDR_W;

	// every piece of state except the array itself and the read buffer in u_buf
	typedef struct packed {
		srp_ctl_t ctl;
		logic [ADDR_W-1:0] addr;
		logic [DW-1:0] din;
		logic [LANES-1:0] lane_n;
		logic [1:0] drv_s;
		logic [1:0] slp_s;
		logic [1:0] ord_s;
		logic active;
		logic rd;
		logic [ADDR_W-1:0] base;
		logic [BW-1:0] beat;
		logic wpend;
		logic [ADDR_W-1:0] waddr;
		srp_pwr_t pwr;
		logic [1:0] pcnt;
		logic [DW-1:0] dout;
		logic drive;
		logic oe;
		logic sleeping;
	} srp_st_t;

	srp_st_t st_reg;
	srp_st_t st_next;
	logic [DW-1:0] mem [DEPTH];
	logic [LANES-1:0] lane_we;
	logic wr_do;
	logic [DW-1:0] wr_data;
	logic [ADDR_W-1:0] rd_addr;
	logic [DW-1:0] rd_word;
	logic qual;
	logic push_valid;
	logic push_ready;
	logic [DW:0] push_data;
	logic pop_valid;
	logic [DW:0] pop_data;
	logic sel_all;
	logic go;

	// a clock rise counts only with the sampled qualifier low
	assign qual = !st_reg.ctl.clock_qualifier_n;
	assign sel_all = !st_reg.ctl.chip_sel_a_n && st_reg.ctl.chip_sel_b
		&& !st_reg.ctl.chip_sel_c_n;
	// a full buffer stalls the array stage rather than drop a word
	assign go = qual && push_ready && (st_reg.pwr == SRP_RUN);

	// burst address of the current or next beat
	function automatic logic [ADDR_W-1:0] beat_addr(
		input logic [ADDR_W-1:0] base,
		input logic [BW-1:0] beat,
		input logic ilv
	);
		logic [BW-1:0] low;
		low = ilv ? (base[BW-1:0] ^ beat) : BW'(base[BW-1:0] + beat);
		return {base[ADDR_W-1:BW], low};
	endfunction : beat_addr

	// next state of the port
	always_comb begin
		st_next = st_reg;
		lane_we = '0;
		wr_do = 1'b0;
		wr_data = st_reg.din;
		rd_addr = st_reg.addr;
		push_valid = 1'b0;
		push_data = '0;
		// two-flop synchronisers; only the second stage is read
		st_next.drv_s = {st_reg.drv_s[0], I_OUT_DRIVE_N};
		st_next.slp_s = {st_reg.slp_s[0], I_SLEEP_REQUEST};
		st_next.ord_s = {st_reg.ord_s[0], I_BURST_ORDER};
		// input registers hold while the array stage is stalled
		if (go || !qual || st_reg.pwr != SRP_RUN) begin
			st_next.ctl = '{clock_qualifier_n: I_CLOCK_QUALIFIER_N,
				chip_sel_a_n: I_CHIP_SEL_A_N, chip_sel_b: I_CHIP_SEL_B,
				chip_sel_c_n: I_CHIP_SEL_C_N, advance_load: I_ADVANCE_LOAD,
				write_sel_n: I_WRITE_SEL_N};
			st_next.addr = I_ADDR;
			st_next.din = I_DATA;
			st_next.lane_n = I_BYTE_LANE_SEL_N;
		end
		if (go) begin
			// data beat of the write started on the previous rise
			if (st_reg.wpend) begin
				wr_do = 1'b1;
				lane_we = ~st_reg.lane_n;
			end
			st_next.wpend = 1'b0;
			if (!st_reg.ctl.advance_load) begin
				if (sel_all) begin
					st_next.active = 1'b1;
					st_next.base = st_reg.addr;
					st_next.beat = '0;
					st_next.rd = st_reg.ctl.write_sel_n;
					rd_addr = st_reg.addr;
					st_next.wpend = !st_reg.ctl.write_sel_n;
					st_next.waddr = st_reg.addr;
				end else begin
					st_next.active = 1'b0;
				end
			end else if (st_reg.active) begin
				// selects and read select are not looked at here
				st_next.beat = st_reg.beat + BW'(1);
				rd_addr = beat_addr(st_reg.base, st_next.beat, st_reg.ord_s[1]);
				st_next.wpend = !st_reg.rd;
				st_next.waddr = rd_addr;
			end
			// one entry per counted rise; only a read beat asks for drive
			push_valid = 1'b1;
			// non-driving beats carry zeros so the lines never show stale array bits
			push_data[DW] = st_next.active && st_next.rd;
			push_data[DW-1:0] = push_data[DW] ? rd_word : '0;
		end
		// a drained entry sets the drive flag and the data
		if (qual && pop_valid) begin
			st_next.drive = pop_data[DW];
			st_next.dout = pop_data[DW-1:0];
		end
		// sleep sequencing, two cycles each way
		st_next.pcnt = st_reg.pcnt + 2'h1;
		case (st_reg.pwr)
			SRP_RUN: begin
				st_next.pcnt = `SRP_RST_CNT;
				if (st_reg.slp_s[1]) begin
					st_next.pwr = SRP_ENTER;
				end
			end
			SRP_ENTER: begin
				st_next.active = 1'b0;
				st_next.wpend = 1'b0;
				st_next.drive = 1'b0;
				if (st_reg.pcnt == 2'(`SRP_SLEEP_ENTER_CYC - 1)) begin
					st_next.pwr = SRP_SLEEP;
					st_next.pcnt = `SRP_RST_CNT;
				end
			end
			SRP_SLEEP: begin
				// a read drained while asleep must not drive after wake-up
				st_next.drive = 1'b0;
				st_next.pcnt = `SRP_RST_CNT;
				if (!st_reg.slp_s[1]) begin
					st_next.pwr = SRP_EXIT;
				end
			end
			SRP_EXIT: begin
				st_next.drive = 1'b0;
				if (st_reg.pcnt == 2'(`SRP_SLEEP_EXIT_CYC - 1)) begin
					st_next.pwr = SRP_RUN;
					st_next.pcnt = `SRP_RST_CNT;
				end
			end
			default: begin
				st_next.pwr = SRP_RUN;
			end
		endcase
		st_next.sleeping = (st_next.pwr != SRP_RUN);
		// output enable is masked on any write or deselect beat
		st_next.oe = st_next.drive && !st_next.drv_s[1]
			&& (st_next.pwr == SRP_RUN);
		// newest written lanes forward into a read of the same word
		wr_data = st_reg.din;
	end

	// array read with write forwarding
	always_comb begin
		rd_word = mem[rd_addr];
		for (int i = 0; i < LANES; i++) begin
			if (wr_do && lane_we[i] && st_reg.waddr == rd_addr) begin
				rd_word[i*`SRP_LANE_W +: `SRP_LANE_W] =
					wr_data[i*`SRP_LANE_W +: `SRP_LANE_W];
			end
		end
	end

	// array write, one generate lane per byte with its parity
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		always_ff @(posedge I_CLK) begin
			if (wr_do && lane_we[g]) begin
				mem[st_reg.waddr][g*`SRP_LANE_W +: `SRP_LANE_W] <=
					wr_data[g*`SRP_LANE_W +: `SRP_LANE_W];
			end
		end
	end

	// read data passes the buffer so a qualifier stall loses no word
	srp_buf2 #(
		.W(DW + 1)
	) u_buf (
		.i_clk(I_CLK),
		.i_rstn(I_RSTN),
		.i_in_valid(push_valid),
		.o_in_ready(push_ready),
		.i_in_data(push_data),
		.o_out_valid(pop_valid),
		.i_out_ready(qual),
		.o_out_data(pop_data)
	);

	// state register; reset leaves the port deselected and floating
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			st_reg <= '0;
			st_reg.ctl <= '{clock_qualifier_n: 1'b1, chip_sel_a_n: 1'b1,
				chip_sel_b: 1'b0, chip_sel_c_n: 1'b1, advance_load: 1'b0,
				write_sel_n: 1'b1};
			st_reg.drv_s <= 2'b11;
			st_reg.slp_s <= `SRP_RST_SYNC;
			st_reg.ord_s <= `SRP_RST_SYNC;
			st_reg.pwr <= SRP_RUN;
			st_reg.pcnt <= `SRP_RST_CNT;
		end else begin
			st_reg <= st_next;
		end
	end

	assign O_DATA = st_reg.dout;
	assign O_DATA_OE = st_reg.oe;
	assign O_SLEEPING = st_reg.sleeping;

endmodule : srp_port

// ==== tb/srp_host.sv ====
/* host controller model driving the port pins one cycle at a time.
   assumes the port clock and the default 36-bit organisation. */
`timescale 1ns/1ps
module srp_host import srp_pkg::*; (
	input wire logic i_clk, // clock
	output srp_ctl_t o_ctl, // control pins
	output logic [3:0] o_be_n, // byte selects
	output logic [17:0] o_addr, // address
	output logic [35:0] o_data, // write data
	output logic o_drive_n, // drive enable
	output logic o_sleep, // sleep request
	output logic o_order // order strap
);
	// deselected and quiet from time zero
	initial begin
		o_ctl = 6'h15;
		o_be_n = 4'hF;
		o_addr = 18'h0;
		o_data = 36'h0;
		o_drive_n = 1'b0;
		o_sleep = 1'b0;
		o_order = 1'b0;
	end
	// one bus cycle; act picks the active selects
	task drv(input logic q, input logic [2:0] act, input logic adv, input logic wn,
		input logic [3:0] be, input logic [17:0] a, input logic [35:0] d, input logic wb);
		@(posedge i_clk);
		o_ctl <= {q, ~act[0], act[1], ~act[2], adv, wn};
		o_be_n <= be;
		o_addr <= a;
		o_data <= wb ? d : ~o_data;
	endtask : drv
	// slow pins change only after an edge
	task misc(input logic dn, input logic sl, input logic od);
		@(posedge i_clk);
		o_drive_n <= dn;
		o_sleep <= sl;
		o_order <= od;
	endtask : misc
endmodule : srp_host

// ==== tb/srp_port_sva.sv ====
/* pin checker of the sram port, bound to each port.
   assumes one clock and an async active-low reset. */
`timescale 1ns/1ps
`include "srp_params.svh"
module srp_port_sva #(
	parameter int ADDR_W = 18,
	parameter int LANES = 4
) (
	input wire logic I_CLK, // clock
	input wire logic I_RSTN, // reset
	input wire logic I_CLOCK_QUALIFIER_N, // qualifier
	input wire logic I_CHIP_SEL_A_N, // select
	input wire logic I_CHIP_SEL_B, // select
	input wire logic I_CHIP_SEL_C_N, // select
	input wire logic I_ADVANCE_LOAD, // advance
	input wire logic I_WRITE_SEL_N, // write
	input wire logic [LANES-1:0] I_BYTE_LANE_SEL_N, // lanes
	input wire logic [ADDR_W-1:0] I_ADDR, // address
	input wire logic [LANES*`SRP_LANE_W-1:0] I_DATA, // data in
	input wire logic I_OUT_DRIVE_N, // drive enable
	input wire logic I_SLEEP_REQUEST, // sleep
	input wire logic I_BURST_ORDER, // strap
	input wire logic [LANES*`SRP_LANE_W-1:0] O_DATA, // data out
	input wire logic O_DATA_OE, // driving
	input wire logic O_SLEEPING // asleep
);
	logic sel, go, q_ok;
	// counted loads while awake; the executing edge needs the qualifier too
	assign sel = !I_CHIP_SEL_A_N && I_CHIP_SEL_B && !I_CHIP_SEL_C_N;
	assign go = !I_CLOCK_QUALIFIER_N && !I_ADVANCE_LOAD && !I_SLEEP_REQUEST && !O_SLEEPING;
	assign q_ok = !I_CLOCK_QUALIFIER_N && !O_SLEEPING;
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RSTN);
	a_read_drives: assert property (!I_OUT_DRIVE_N[*3] ##0 go && sel && I_WRITE_SEL_N
		##1 q_ok && !I_OUT_DRIVE_N |=> ##1 O_DATA_OE)
		else $error("read did not drive");
	a_write_floats: assert property (go && sel && !I_WRITE_SEL_N ##1 q_ok |=> ##1 !O_DATA_OE)
		else $error("write left lines driven");
	a_desel_floats: assert property (go && !sel ##1 q_ok |=> ##1 !O_DATA_OE)
		else $error("deselect left lines driven");
	a_drive_off: assert property (I_OUT_DRIVE_N[*3] |=> !O_DATA_OE)
		else $error("driven with enable off");
	a_stall_holds: assert property (I_CLOCK_QUALIFIER_N && !I_SLEEP_REQUEST |-> ##2 $stable(O_DATA))
		else $error("data moved on ignored edge");
	a_reset_quiet: assert property (disable iff (1'b0) !I_RSTN |-> !O_DATA_OE && !O_SLEEPING)
		else $error("outputs active in reset");
	a_sleep_entry: assert property ($rose(I_SLEEP_REQUEST) |-> ##[2:4] O_SLEEPING)
		else $error("sleep entry late");
	a_sleep_wake: assert property ($fell(I_SLEEP_REQUEST) |-> ##[4:8] !O_SLEEPING)
		else $error("sleep exit late");
	c_read: cover property (go && sel ##2 O_DATA_OE);
	c_stall: cover property (I_CLOCK_QUALIFIER_N[*2]);
	c_sleep: cover property ($rose(O_SLEEPING));
endmodule : srp_port_sva
bind srp_port srp_port_sva #(.ADDR_W(ADDR_W), .LANES(LANES)) sva_u (.I_CLK(I_CLK),
	.I_RSTN(I_RSTN), .I_CLOCK_QUALIFIER_N(I_CLOCK_QUALIFIER_N),
	.I_CHIP_SEL_A_N(I_CHIP_SEL_A_N), .I_CHIP_SEL_B(I_CHIP_SEL_B),
	.I_CHIP_SEL_C_N(I_CHIP_SEL_C_N), .I_ADVANCE_LOAD(I_ADVANCE_LOAD),
	.I_WRITE_SEL_N(I_WRITE_SEL_N), .I_BYTE_LANE_SEL_N(I_BYTE_LANE_SEL_N), .I_ADDR(I_ADDR),
	.I_DATA(I_DATA), .I_OUT_DRIVE_N(I_OUT_DRIVE_N), .I_SLEEP_REQUEST(I_SLEEP_REQUEST),
	.I_BURST_ORDER(I_BURST_ORDER), .O_DATA(O_DATA), .O_DATA_OE(O_DATA_OE),
	.O_SLEEPING(O_SLEEPING));

// ==== tb/flow_through_burst_sram_port_test.sv ====
/* testbench of the sram port: host model, port, scenario tasks.
   assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ps
module flow_through_burst_sram_port_test;
	logic clk, rstn, dn, slp, ord, oe, sleeping;
	srp_pkg::srp_ctl_t ctl;
	logic [3:0] be_n;
	logic [17:0] addr;
	logic [35:0] din, dout;
	int fails = 0;
	int tests_run = 0;
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	srp_host host_u (.i_clk(clk), .o_ctl(ctl), .o_be_n(be_n), .o_addr(addr), .o_data(din),
		.o_drive_n(dn), .o_sleep(slp), .o_order(ord));
	srp_port dut_u (.I_CLK(clk), .I_RSTN(rstn), .I_CLOCK_QUALIFIER_N(ctl.clock_qualifier_n),
		.I_CHIP_SEL_A_N(ctl.chip_sel_a_n), .I_CHIP_SEL_B(ctl.chip_sel_b),
		.I_CHIP_SEL_C_N(ctl.chip_sel_c_n), .I_ADVANCE_LOAD(ctl.advance_load),
		.I_WRITE_SEL_N(ctl.write_sel_n), .I_BYTE_LANE_SEL_N(be_n), .I_ADDR(addr), .I_DATA(din),
		.I_OUT_DRIVE_N(dn), .I_SLEEP_REQUEST(slp), .I_BURST_ORDER(ord), .O_DATA(dout),
		.O_DATA_OE(oe), .O_SLEEPING(sleeping));
	task chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task final_report();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	function automatic logic [35:0] pat(input int k);
		return {4{k[8:0]}} ^ 36'hA_5C3A_5C3A;
	endfunction : pat
	// deselect loads, so the next op starts from a fresh address
	task idle(input int n);
		repeat (n) host_u.drv(0, 0, 0, 1, 4'hF, 0, 0, 0);
	endtask : idle
	task step();
		@(posedge clk);
		#1;
	endtask : step
	// read at c0, result stands after c2
	task rd(input logic [17:0] a, input logic eoe, input logic [35:0] ed);
		host_u.drv(0, 3'h7, 0, 1, 4'hF, a, 0, 0);
		idle(2);
		step();
		chk("drive", oe, eoe);
		if (eoe)
			chk("data", dout, ed);
	endtask : rd
	// data beat rides with a deselect in the next cycle
	task wr(input logic [17:0] a, input logic [3:0] be, input logic [35:0] d);
		host_u.drv(0, 3'h7, 0, 0, 4'hF, a, 0, 0);
		host_u.drv(0, 0, 0, 1, be, 0, d, 1);
	endtask : wr
	task wait_sl(input logic lvl, output int n);
		for (n = 0; n < 20 && sleeping !== lvl; n++)
			step();
		if (n == 20) begin
			fails++;
			final_report();
		end
	endtask : wait_sl
	task t_single();
		host_u.drv(0, 3'h7, 0, 0, 4'hF, 18'h5, 0, 0);
		host_u.drv(0, 3'h7, 0, 1, 4'h0, 18'h5, pat(5), 1);
		idle(2);
		step();
		chk("b2b", dout, pat(5));
		wr(18'h9, 4'h0, pat(9));
		rd(18'h9, 1, pat(9));
		$display("single done");
	endtask : t_single
	task t_bytes();
		wr(18'h20, 4'h0, pat(1));
		wr(18'h20, 4'hA, ~pat(1));
		wr(18'h20, 4'hF, 36'h0);
		rd(18'h20, 1, pat(1) ^ 36'h0_07FC_01FF);
		$display("bytes done");
	endtask : t_bytes
	task t_burst();
		int i;
		host_u.drv(0, 3'h7, 0, 0, 4'hF, 18'h43, 0, 0);
		for (i = 0; i < 4; i++)
			host_u.drv(0, 0, i < 3, 1, 4'h0, 0, pat(i), 1);
		for (i = 0; i < 4; i++)
			rd(18'h40 | 18'((3 + i) & 3), 1, pat(i));
		host_u.misc(0, 0, 1);
		idle(3);
		host_u.drv(0, 3'h7, 0, 1, 4'hF, 18'h41, 0, 0);
		for (i = 0; i < 6; i++) begin
			host_u.drv(0, 0, i < 3, 1, 4'hF, 0, 0, 0);
			#1;
			if (i >= 2)
				chk("ilv", dout, pat(((1 ^ (i - 2)) - 3) & 3));
		end
		host_u.misc(0, 0, 0);
		idle(3);
		$display("burst done");
	endtask : t_burst
	// a read shows, then stalled write commands must neither act nor move it
	task t_stall();
		rd(18'h9, 1, pat(9));
		host_u.drv(0, 3'h7, 0, 1, 4'hF, 18'h9, 0, 0);
		idle(1);
		repeat (4) host_u.drv(1, 3'h7, 0, 0, 4'h0, 18'h9, 0, 1);
		#1;
		chk("stall", dout, pat(9));
		chk("stall oe", oe, 1);
		idle(2);
		rd(18'h9, 1, pat(9));
		$display("stall done");
	endtask : t_stall
	task t_desel();
		int i;
		for (i = 0; i < 3; i++) begin
			host_u.drv(0, 3'h7, 0, 1, 4'hF, 18'h9, 0, 0);
			host_u.drv(0, 3'h7 ^ (3'h1 << i), 0, 1, 4'hF, 18'h9, 0, 0);
			idle(1);
			step();
			chk("read", oe, 1);
			step();
			chk("desel", oe, 0);
		end
		host_u.misc(1, 0, 0);
		idle(2);
		rd(18'h9, 0, 0);
		host_u.misc(0, 0, 0);
		$display("deselect done");
	endtask : t_desel
	task t_sleep();
		int n;
		idle(2);
		host_u.misc(0, 1, 0);
		wait_sl(1, n);
		// two synchroniser flops, then the state step
		chk("enter", n, 3);
		idle(6);
		host_u.misc(0, 0, 0);
		wait_sl(0, n);
		// two synchroniser flops, one step into exit, two exit cycles
		chk("leave", n, 5);
		idle(2);
		rd(18'h9, 1, pat(9));
		$display("sleep done");
	endtask : t_sleep
	initial begin
		rstn = 1'b0;
		repeat (12) @(posedge clk);
		chk("reset oe", oe, 0);
		chk("reset sleep", sleeping, 0);
		rstn <= 1'b1;
		t_single();
		t_bytes();
		t_burst();
		t_stall();
		t_desel();
		t_sleep();
		final_report();
	end
endmodule : flow_through_burst_sram_port_test
